//--- tb/scre_exec_props.sv
// Timing and flag checks on the executer ports
`timescale 1ns/1ps
`default_nettype none
module scre_exec_props
(
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_start,
   input wire logic [7:0]  i_opcode,
   input wire logic [7:0]  i_operand_a,
   input wire logic [15:0] i_sp,
   input wire logic [7:0]  i_flags,
   input wire logic        o_busy,
   input wire logic        o_done,
   input wire logic [1:0]  o_len,
   input wire logic [7:0]  o_rf_addr,
   input wire logic [7:0]  o_rf_wdata,
   input wire logic        o_rf_wr,
   input wire logic [15:0] o_stk_addr,
   input wire logic        o_stk_rd,
   input wire logic [15:0] o_sp_next,
   input wire logic        o_sp_wr,
   input wire logic        o_pc_load,
   input wire logic [7:0]  o_flags,
   input wire logic        o_flags_wr
);
   logic take;
   assign take = i_start && !o_busy;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   chk_push_done: assert property (take && i_opcode == 8'h83 |-> ##8 o_done && o_len == 2'h3)
      else $error("push finish wrong");
   chk_push_no_flag: assert property (take && i_opcode == 8'h83 |-> ##1 !o_flags_wr [*8])
      else $error("push touched flags");
   chk_push_ptr_first: assert property (take && i_opcode == 8'h83
      |-> ##2 o_rf_wr && o_rf_addr == $past(i_operand_a, 2))
      else $error("push pointer not updated first");
   chk_clear_carry: assert property (take && i_opcode == 8'hCF
      |-> ##1 o_flags_wr && o_flags == ($past(i_flags) & 8'h7F) ##3 o_done && o_len == 2'h1)
      else $error("carry clear wrong");
   chk_exit_reads: assert property (take && i_opcode == 8'hAF
      |-> ##1 o_stk_rd && o_stk_addr == $past(i_sp)
      ##1 o_stk_rd && o_stk_addr == $past(i_sp, 2) + 16'h0001)
      else $error("return stack reads wrong");
   chk_exit_sp_step: assert property (take && i_opcode == 8'hAF
      |-> ##3 o_sp_wr && o_sp_next == $past(i_sp, 3) + 16'h0002 ##5 o_done && o_len == 2'h1)
      else $error("return pointer step wrong");
   chk_rot_done: assert property (take && i_opcode == 8'h90 |-> ##4 o_done && o_len == 2'h2)
      else $error("rotate finish wrong");
   chk_rot_flags: assert property (o_rf_wr && o_flags_wr |-> o_flags[7] == o_rf_wdata[0]
      && o_flags[6] == (o_rf_wdata == 8'h00) && o_flags[5] == o_rf_wdata[7])
      else $error("rotate flags disagree with result");
   chk_rot_overflow: assert property (o_rf_wr && o_flags_wr |-> o_flags[4] == (o_flags[5] ^ o_flags[7]))
      else $error("rotate overflow flag wrong");
   chk_rot_ind_done: assert property (take && i_opcode == 8'h91 |-> ##4 o_done && o_len == 2'h2)
      else $error("indirect rotate finish wrong");
   chk_exit_pc_load: assert property (take && i_opcode == 8'hAF |-> ##3 o_pc_load && !o_flags_wr)
      else $error("return counter load wrong");
   chk_done_idle: assert property (o_done |-> !o_busy)
      else $error("finish pulse while busy");
endmodule
bind scre_exec scre_exec_props scre_exec_props_inst (.i_clk, .i_nrst, .i_start, .i_opcode,
   .i_operand_a, .i_sp, .i_flags, .o_busy, .o_done, .o_len, .o_rf_addr, .o_rf_wdata, .o_rf_wr,
   .o_stk_addr, .o_stk_rd, .o_sp_next, .o_sp_wr, .o_pc_load, .o_flags, .o_flags_wr);
`default_nettype wire

//--- tb/scre_exec_tb_top.sv
// Self-checking bench for the stack, carry and rotate executer
`timescale 1ns/1ps
`default_nettype none
module scre_exec_tb_top;
   logic        i_clk, i_nrst, i_start, o_busy, o_done, o_illegal, o_rf_rd, o_rf_wr;
   logic        o_stk_rd, o_sp_wr, o_pc_load, o_flags_wr;
   logic [7:0]  i_opcode, i_operand_a, i_operand_b, i_rf_rdata, i_stk_rdata, i_flags;
   logic [7:0]  o_rf_addr, o_rf_wdata, o_flags, v, r;
   logic [15:0] i_sp, o_stk_addr, o_sp_next, o_pc;
   logic [1:0]  o_len;
   logic [7:0]  vals [5] = '{8'hAA, 8'h00, 8'h40, 8'h80, 8'h01};
   int          n_mismatch = 0;
   int          check_count = 0;
   scre_exec scre_exec_inst (.i_clk, .i_nrst, .i_start, .i_opcode, .i_operand_a, .i_operand_b,
      .i_rf_rdata, .i_stk_rdata, .i_sp, .i_flags, .o_busy, .o_done, .o_len, .o_illegal,
      .o_rf_addr, .o_rf_wdata, .o_rf_rd, .o_rf_wr, .o_stk_addr, .o_stk_rd, .o_sp_next,
      .o_sp_wr, .o_pc, .o_pc_load, .o_flags, .o_flags_wr);
   scre_partner p (.i_clk, .i_rf_addr(o_rf_addr), .i_rf_wdata(o_rf_wdata), .i_rf_rd(o_rf_rd),
      .i_rf_wr(o_rf_wr), .i_stk_addr(o_stk_addr), .i_stk_rd(o_stk_rd), .i_sp_next(o_sp_next),
      .i_sp_wr(o_sp_wr), .i_flags_new(o_flags), .i_flags_wr(o_flags_wr),
      .o_rf_rdata(i_rf_rdata), .o_stk_rdata(i_stk_rdata), .o_sp(i_sp), .o_flags(i_flags));
   task automatic conclude();
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One instruction, then wait for its finish pulse
   task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                      input logic [1:0] len, input logic ill);
      int n;
      @(posedge i_clk);
      i_opcode    <= op;
      i_operand_a <= a;
      i_operand_b <= b;
      i_start     <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      n = 0;
      do
      begin
         @(negedge i_clk);
         n++;
      end while (o_done !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         n_mismatch++;
         conclude();
      end
      chk("illegal", 16'(ill), 16'(o_illegal));
      if (!ill) chk("length", 16'(len), 16'(o_len));
   endtask
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial
   begin
      i_nrst = 1'b0;
      i_start = 1'b0;
      i_opcode = 8'h00;
      i_operand_a = 8'h00;
      i_operand_b = 8'h00;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk);
      p.rf[8'h00] = 8'h03;
      p.rf[8'h01] = 8'h05;
      p.rf[8'h10] = 8'hFF;
      p.rf[8'h11] = 8'hA5;
      p.o_flags = 8'hFF;
      run(8'h83, 8'h00, 8'h01, 2'h3, 1'b0);
      chk("push ptr", 16'h0004, 16'(p.rf[8'h00]));
      chk("push data", 16'h0005, 16'(p.rf[8'h04]));
      run(8'h83, 8'h10, 8'h11, 2'h3, 1'b0);
      chk("wrap ptr", 16'h0000, 16'(p.rf[8'h10]));
      chk("wrap data", 16'h00A5, 16'(p.rf[8'h00]));
      chk("push flags", 16'h00FF, 16'(i_flags));
      run(8'hCF, 8'h00, 8'h00, 2'h1, 1'b0);
      chk("carry set", 16'h007F, 16'(i_flags));
      run(8'hCF, 8'h00, 8'h00, 2'h1, 1'b0);
      chk("carry clear", 16'h007F, 16'(i_flags));
      p.o_sp = 16'h00FC;
      p.stk[8'hFC] = 8'h10;
      p.stk[8'hFD] = 8'h1A;
      p.stk[8'hFE] = 8'h20;
      p.stk[8'hFF] = 8'h01;
      p.o_flags = 8'h55;
      run(8'hAF, 8'h00, 8'h00, 2'h1, 1'b0);
      chk("pc", 16'h101A, o_pc);
      chk("sp", 16'h00FE, i_sp);
      run(8'hAF, 8'h00, 8'h00, 2'h1, 1'b0);
      chk("pc again", 16'h2001, o_pc);
      chk("sp again", 16'h0100, i_sp);
      chk("exit flags", 16'h0055, 16'(i_flags));
      foreach (vals[i])
      begin
         v = vals[i];
         r = {v[6:0], v[7]};
         p.rf[8'h20] = v;
         p.o_flags = 8'h8A;
         run(8'h90, 8'h20, 8'h00, 2'h2, 1'b0);
         chk("rotate", 16'(r), 16'(p.rf[8'h20]));
         chk("rot flags", 16'({v[7], r == 8'h00, r[7], r[7] ^ v[7], 4'hA}), 16'(i_flags));
      end
      p.rf[8'h01] = 8'h02;
      p.rf[8'h02] = 8'h17;
      run(8'h91, 8'h01, 8'h00, 2'h2, 1'b0);
      chk("rot ind", 16'h002E, 16'(p.rf[8'h02]));
      chk("rot ptr", 16'h0002, 16'(p.rf[8'h01]));
      chk("rot ind c", 16'h0000, 16'(i_flags[7]));
      run(8'h00, 8'h00, 8'h00, 2'h0, 1'b1);
      conclude();
   end
endmodule
`default_nettype wire

//--- tb/scre_partner.sv
// Register file, stack memory, stack pointer and flags beside the executer
`timescale 1ns/1ps
`default_nettype none
module scre_partner
(
   input  wire logic        i_clk,
   input  wire logic [7:0]  i_rf_addr,
   input  wire logic [7:0]  i_rf_wdata,
   input  wire logic        i_rf_rd,
   input  wire logic        i_rf_wr,
   input  wire logic [15:0] i_stk_addr,
   input  wire logic        i_stk_rd,
   input  wire logic [15:0] i_sp_next,
   input  wire logic        i_sp_wr,
   input  wire logic [7:0]  i_flags_new,
   input  wire logic        i_flags_wr,
   output logic      [7:0]  o_rf_rdata,
   output logic      [7:0]  o_stk_rdata,
   output logic      [15:0] o_sp,
   output logic      [7:0]  o_flags
);
   logic [7:0] rf  [256];
   logic [7:0] stk [256];
   initial
   begin
      o_sp        = 16'h0000;
      o_flags     = 8'h00;
   end
   // Read data stands only while its strobe does, inverted otherwise; stack decodes low byte
   assign o_rf_rdata  = i_rf_rd ? rf[i_rf_addr] : ~rf[i_rf_addr];
   assign o_stk_rdata = i_stk_rd ? stk[i_stk_addr[7:0]] : ~stk[i_stk_addr[7:0]];
   always @(posedge i_clk)
   begin
      if (i_rf_wr) rf[i_rf_addr] <= i_rf_wdata;
      o_sp    <= i_sp_wr ? i_sp_next : o_sp;
      o_flags <= i_flags_wr ? i_flags_new : o_flags;
   end
endmodule
`default_nettype wire

//--- verilog/scre_defs.svh
// Constants for the stack, carry and rotate execution block
`ifndef SCRE_DEFS_SVH
`define SCRE_DEFS_SVH
`define SCRE_OP_PUSH_INC   8'h83
`define SCRE_OP_CLR_CARRY  8'hCF
`define SCRE_OP_EXIT       8'hAF
`define SCRE_OP_ROT_DIR    8'h90
`define SCRE_OP_ROT_IND    8'h91
`define SCRE_CYC_PUSH      4'h8
`define SCRE_CYC_CLR       4'h4
`define SCRE_CYC_EXIT      4'h8
`define SCRE_CYC_ROT       4'h4
`define SCRE_LEN_PUSH      2'h3
`define SCRE_LEN_CLR       2'h1
`define SCRE_LEN_EXIT      2'h1
`define SCRE_LEN_ROT       2'h2
`define SCRE_SP_STEP       16'h0002
`define SCRE_FLAG_C        7
`define SCRE_FLAG_Z        6
`define SCRE_FLAG_S        5
`define SCRE_FLAG_V        4
`endif

//--- verilog/scre_exec.sv
// Executes the incrementing user push, carry clear, return and rotate left
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scre_defs.svh"
module scre_exec
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_start,
   input  wire logic [7:0]  i_opcode,
   input  wire logic [7:0]  i_operand_a,
   input  wire logic [7:0]  i_operand_b,
   input  wire logic [7:0]  i_rf_rdata,
   input  wire logic [7:0]  i_stk_rdata,
   input  wire logic [15:0] i_sp,
   input  wire logic [7:0]  i_flags,
   output logic             o_busy,
   output logic             o_done,
   output logic [1:0]       o_len,
   output logic             o_illegal,
   output logic [7:0]       o_rf_addr,
   output logic [7:0]       o_rf_wdata,
   output logic             o_rf_rd,
   output logic             o_rf_wr,
   output logic [15:0]      o_stk_addr,
   output logic             o_stk_rd,
   output logic [15:0]      o_sp_next,
   output logic             o_sp_wr,
   output logic [15:0]      o_pc,
   output logic             o_pc_load,
   output logic [7:0]       o_flags,
   output logic             o_flags_wr
);
   import scre_pkg::*;

   scre_state_s r;
   scre_state_s next_r;
   logic        rst_n;

   assign rst_n = r.rst_sync[1];

   function automatic scre_kind_e decode(input logic [7:0] op);
      unique case (op)
         `SCRE_OP_PUSH_INC  : decode = SCRE_K_PUSH;
         `SCRE_OP_CLR_CARRY : decode = SCRE_K_CLR;
         `SCRE_OP_EXIT      : decode = SCRE_K_EXIT;
         `SCRE_OP_ROT_DIR   : decode = SCRE_K_ROTD;
         `SCRE_OP_ROT_IND   : decode = SCRE_K_ROTI;
         default            : decode = SCRE_K_NONE;
      endcase
   endfunction

   function automatic logic [7:0] rotl_flags(input logic [7:0] f, input logic [7:0] v);
      logic [7:0] res;
      logic [7:0] o;
      res = {v[6:0], v[7]};
      o = f;
      o[`SCRE_FLAG_C] = v[7];
      o[`SCRE_FLAG_Z] = (res == 8'h00);
      o[`SCRE_FLAG_S] = res[7];
      o[`SCRE_FLAG_V] = res[7] ^ v[7];
      rotl_flags = o;
   endfunction

   always_comb
   begin
      next_r = r;
      next_r.rst_sync = {r.rst_sync[0], 1'b1};
      next_r.rf_rd    = 1'b0;
      next_r.rf_wr    = 1'b0;
      next_r.stk_rd   = 1'b0;
      next_r.pc_load  = 1'b0;
      next_r.flags_wr = 1'b0;
      next_r.done     = 1'b0;
      if (r.cyc != 4'h0)
      begin
         next_r.cyc = r.cyc - 4'h1;
      end
      unique case (r.state)
         SCRE_IDLE:
         begin
            if (i_start && rst_n)
            begin
               next_r.kind  = decode(i_opcode);
               next_r.a_reg = i_operand_a;
               next_r.b_reg = i_operand_b;
               next_r.state = SCRE_RD_A;
               unique case (decode(i_opcode))
                  SCRE_K_PUSH:
                  begin
                     // Fetch user stack pointer
                     next_r.cyc     = `SCRE_CYC_PUSH - 4'h1;
                     next_r.len     = `SCRE_LEN_PUSH;
                     next_r.rf_addr = i_operand_a;
                     next_r.rf_rd   = 1'b1;
                  end
                  SCRE_K_CLR:
                  begin
                     next_r.cyc   = `SCRE_CYC_CLR - 4'h1;
                     next_r.len   = `SCRE_LEN_CLR;
                     next_r.flags = i_flags;
                     next_r.flags[`SCRE_FLAG_C] = 1'b0;
                     next_r.flags_wr = 1'b1;
                     next_r.state = SCRE_WAIT;
                  end
                  SCRE_K_EXIT:
                  begin
                     next_r.cyc      = `SCRE_CYC_EXIT - 4'h1;
                     next_r.len      = `SCRE_LEN_EXIT;
                     next_r.stk_addr = i_sp;
                     next_r.stk_rd   = 1'b1;
                  end
                  SCRE_K_ROTD, SCRE_K_ROTI:
                  begin
                     next_r.cyc     = `SCRE_CYC_ROT - 4'h1;
                     next_r.len     = `SCRE_LEN_ROT;
                     next_r.rf_addr = i_operand_a;
                     next_r.rf_rd   = 1'b1;
                  end
                  default:
                  begin
                     next_r.cyc   = 4'h0;
                     next_r.len   = 2'h1;
                     next_r.state = SCRE_DONE;
                  end
               endcase
            end
         end
         SCRE_RD_A:
         begin
            unique case (r.kind)
               SCRE_K_PUSH:
               begin
                  next_r.ptr      = i_rf_rdata + 8'h01;
                  next_r.rf_addr  = r.a_reg;
                  next_r.rf_wdata = i_rf_rdata + 8'h01;
                  next_r.rf_wr    = 1'b1;
                  next_r.state    = SCRE_RD_B;
               end
               SCRE_K_EXIT:
               begin
                  next_r.pc_hi    = i_stk_rdata;
                  next_r.stk_addr = r.stk_addr + 16'h0001;
                  next_r.stk_rd   = 1'b1;
                  next_r.state    = SCRE_RD_B;
               end
               SCRE_K_ROTI:
               begin
                  // Indirect: fetched byte is the target address
                  next_r.ptr     = i_rf_rdata;
                  next_r.rf_addr = i_rf_rdata;
                  next_r.rf_rd   = 1'b1;
                  next_r.state   = SCRE_RD_C;
               end
               default:
               begin
                  next_r.data  = i_rf_rdata;
                  next_r.ptr   = r.a_reg;
                  next_r.state = SCRE_WR;
               end
            endcase
         end
         SCRE_RD_C:
         begin
            if (r.kind == SCRE_K_ROTI)
            begin
               // Pointed byte is rotated and written back at once
               next_r.rf_addr  = r.ptr;
               next_r.rf_wdata = {i_rf_rdata[6:0], i_rf_rdata[7]};
               next_r.flags    = rotl_flags(i_flags, i_rf_rdata);
               next_r.flags_wr = 1'b1;
               next_r.rf_wr    = 1'b1;
               next_r.state    = SCRE_WAIT;
            end
            else
            begin
               next_r.data  = i_rf_rdata;
               next_r.state = SCRE_WR;
            end
         end
         SCRE_RD_B:
         begin
            if (r.kind == SCRE_K_PUSH)
            begin
               next_r.rf_addr = r.b_reg;
               next_r.rf_rd   = 1'b1;
               next_r.state   = SCRE_RD_C;
               next_r.kind    = SCRE_K_PUSH;
            end
            else
            begin
               next_r.pc      = {r.pc_hi, i_stk_rdata};
               next_r.pc_load = 1'b1;
               next_r.state   = SCRE_WAIT;
            end
         end
         SCRE_WR:
         begin
            if (r.kind == SCRE_K_PUSH)
            begin
               next_r.rf_addr  = r.ptr;
               next_r.rf_wdata = r.data;
            end
            else
            begin
               next_r.rf_addr  = r.ptr;
               next_r.rf_wdata = {r.data[6:0], r.data[7]};
               next_r.flags    = rotl_flags(i_flags, r.data);
               next_r.flags_wr = 1'b1;
            end
            next_r.rf_wr = 1'b1;
            next_r.state = SCRE_WAIT;
         end
         SCRE_WAIT:
         begin
            if (r.cyc <= 4'h1)
            begin
               // Finish pulse stands in the last counted cycle
               next_r.done  = 1'b1;
               next_r.state = SCRE_IDLE;
            end
         end
         SCRE_DONE:
         begin
            next_r.done  = 1'b1;
            next_r.state = SCRE_IDLE;
         end
         default:
         begin
            next_r.state = SCRE_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         r       <= '0;
         r.state <= SCRE_IDLE;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign o_busy     = (r.state != SCRE_IDLE);
   assign o_done     = r.done;
   assign o_len      = r.len;
   assign o_illegal  = r.done && (r.kind == SCRE_K_NONE);
   assign o_rf_addr  = r.rf_addr;
   assign o_rf_wdata = r.rf_wdata;
   assign o_rf_rd    = r.rf_rd;
   assign o_rf_wr    = r.rf_wr;
   assign o_stk_addr = r.stk_addr;
   assign o_stk_rd   = r.stk_rd;
   assign o_sp_next  = r.stk_addr - 16'h0001 + `SCRE_SP_STEP;
   assign o_sp_wr    = r.pc_load;
   assign o_pc       = r.pc;
   assign o_pc_load  = r.pc_load;
   assign o_flags    = r.flags;
   assign o_flags_wr = r.flags_wr;
endmodule
`default_nettype wire

//--- verilog/scre_pkg.sv
// Types for the stack, carry and rotate execution block
`default_nettype none
package scre_pkg;
   typedef enum logic [6:0] {
      SCRE_IDLE  = 7'h01,
      SCRE_RD_A  = 7'h02,
      SCRE_RD_B  = 7'h04,
      SCRE_WR    = 7'h08,
      SCRE_WAIT  = 7'h10,
      SCRE_DONE  = 7'h20,
      SCRE_RD_C  = 7'h40
   } scre_state_e;

   typedef enum logic [2:0] {
      SCRE_K_NONE = 3'h0,
      SCRE_K_PUSH = 3'h1,
      SCRE_K_CLR  = 3'h2,
      SCRE_K_EXIT = 3'h3,
      SCRE_K_ROTD = 3'h4,
      SCRE_K_ROTI = 3'h5
   } scre_kind_e;

   typedef struct packed {
      logic [1:0]  rst_sync;
      scre_state_e state;
      scre_kind_e  kind;
      logic [7:0]  a_reg;
      logic [7:0]  b_reg;
      logic [7:0]  ptr;
      logic [7:0]  data;
      logic [3:0]  cyc;
      logic [7:0]  rf_addr;
      logic [7:0]  rf_wdata;
      logic        rf_rd;
      logic        rf_wr;
      logic [15:0] stk_addr;
      logic        stk_rd;
      logic [7:0]  pc_hi;
      logic [15:0] pc;
      logic        pc_load;
      logic [7:0]  flags;
      logic        flags_wr;
      logic        done;
      logic [1:0]  len;
   } scre_state_s;
endpackage
`default_nettype wire
